// ==== sbrg_pkg.sv ====
// Purpose: Shared constants for the serial bit-rate generator block.
// Assumes: 32-bit AHB-Lite register bus, one word per register.
// Notes:   Offsets are byte addresses; fields sit in the low bits.
package sbrg_pkg;
   // Byte offsets of the registers.
   localparam logic [7:0] ADDR_BIT_RATE_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_RX_DATA = 8'h04;
   localparam logic [7:0] ADDR_EVENT_STATUS = 8'h08;
   localparam logic [7:0] ADDR_EVENT_MASK = 8'h0c;
   // Field positions of bit_rate_control.
   localparam int CTL_SECOND_LSB = 0;
   localparam int CTL_CLOCK_TEST = 3;
   localparam int CTL_FIRST_LSB = 4;
   localparam int CTL_SPI_SOURCE = 6;
   localparam int CTL_CHAIN_CLEAR = 7;
   // Field positions of the event status and mask registers.
   localparam int EVT_RECEIVE_FULL = 0;
   localparam int EVT_OVERRUN = 1;
   localparam int EVT_FRAMING = 2;
   localparam int EVT_COUNT = 3;
   // Reset values.
   localparam logic [7:0] RST_BIT_RATE_CONTROL = 8'h00;
   localparam logic [2:0] RST_EVENT_MASK = 3'h0;
   // First-stage divide factors for codes 00, 01, 10 and 11.
   localparam logic [3:0] FIRST_FACTOR_0 = 4'h1;
   localparam logic [3:0] FIRST_FACTOR_1 = 4'h3;
   localparam logic [3:0] FIRST_FACTOR_2 = 4'h4;
   localparam logic [3:0] FIRST_FACTOR_3 = 4'hd;
   // Receiver sample ticks per transmit bit.
   localparam logic [4:0] SAMPLES_PER_BIT = 5'h10;
   // Largest second-stage factor and its counter width.
   localparam int SECOND_FACTOR_MAX = 128;
   localparam int SECOND_CNT_W = 7;
   // Receive character width, ninth bit included.
   localparam int RX_DATA_W = 9;
   // AHB transfer type that starts a single transfer.
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage

// ==== sbrg_top.sv ====
// Purpose: Bit-rate generator and receive-data gating of a serial unit.
// Assumes: Single bus clock; receiver and transmitter share this clock.
// Notes:   Registers are reached over AHB-Lite with zero wait states.
//
// Functional notes
// - Framing error blocks receive data transfers.
// - Framing flag sets with full flag, never on overrun.
// - Transmit and receive share one two-stage rate.
// - Rate is bus clock over 16, factor1, factor2.
// - First factor codes give 1, 3, 4, 13.
// - Second factor is two to the field value.
// - Chain clear resets counters only in test mode.
// - Chain clear is momentary and reads zero.
// - Source select routes receiver or bus clock.
// - Clock test bit test-mode only, reads zero.
// - Clock test drives clock XOR onto output.
// - Wait state keeps running; interrupts wake system.
// - Transmit bit is sixteen receiver sample ticks.
`timescale 1ns/1ps
`default_nettype none
module sbrg_top (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clock_enable,
   // AHB-Lite slave port.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   // Mode strap from the mode logic on this clock: test or bootstrap.
   input wire logic test_or_boot_mode,
   // Receiver shift register hands over one character per pulse.
   input wire logic rx_shift_done,
   input wire logic [sbrg_pkg::RX_DATA_W-1:0] rx_shift_data,
   input wire logic rx_stop_bad,
   // Transmit shift register output bit.
   input wire logic tx_line_bit,
   // Clock-enable pulses for receiver, transmitter and SPI.
   output logic rx_sample_tick,
   output logic tx_bit_tick,
   output logic spi_clock_tick,
   output logic serial_output_pin,
   output logic receive_full_flag,
   output logic framing_error_flag,
   output logic irq,
   output logic wake_request
);
   // All state of the block in one record.
   typedef struct packed {
      logic [1:0] first_sel; // First-stage select field.
      logic [2:0] second_sel; // Second-stage select field.
      logic spi_src; // SPI clock source select.
      logic clk_test; // Divider clock-test mode.
      logic [3:0] p1_cnt; // First-stage counter.
      logic [sbrg_pkg::SECOND_CNT_W-1:0] p2_cnt; // Second-stage counter.
      logic [3:0] tx_cnt; // Sample ticks within one bit.
      logic rx_lvl; // Toggles on each receiver sample tick.
      logic tx_lvl; // Toggles on each transmit bit tick.
      logic ser_out; // Registered serial output pin.
      logic [sbrg_pkg::RX_DATA_W-1:0] rx_data; // Receive data register.
      logic rf; // Receive full flag.
      logic ovr; // Overrun flag.
      logic fe; // Framing error flag.
      logic [sbrg_pkg::EVT_COUNT-1:0] mask; // Interrupt mask.
      logic wr_pend; // Write data phase pending.
      logic rd_pend; // Read data phase pending.
      logic [7:0] addr; // Byte address of the pending transfer.
   } sbrg_state_t;

   sbrg_state_t state_q;
   sbrg_state_t state_d;

   // Terminal count of the first stage: factor minus one.
   function automatic logic [3:0] sbrg_first_term(input logic [1:0] code);
      logic [3:0] f;
      f = sbrg_pkg::FIRST_FACTOR_0;
      unique case (code)
         2'h0: f = sbrg_pkg::FIRST_FACTOR_0;
         2'h1: f = sbrg_pkg::FIRST_FACTOR_1;
         2'h2: f = sbrg_pkg::FIRST_FACTOR_2;
         2'h3: f = sbrg_pkg::FIRST_FACTOR_3;
      endcase
      return f - 4'h1;
   endfunction

   // Terminal count of the second stage: two to the code, minus one.
   function automatic logic [sbrg_pkg::SECOND_CNT_W-1:0] sbrg_second_term(
      input logic [2:0] code);
      logic [sbrg_pkg::SECOND_CNT_W:0] f;
      f = (sbrg_pkg::SECOND_CNT_W+1)'(1) << code;
      return sbrg_pkg::SECOND_CNT_W'(f - 1'b1);
   endfunction

   // Elaboration check: the counter must hold the largest factor.
   if ((1 << sbrg_pkg::SECOND_CNT_W) != sbrg_pkg::SECOND_FACTOR_MAX) begin
      $error("Second-stage counter width does not fit the factor table.");
   end

   logic addr_take; // Address phase accepted this cycle.
   logic first_tick; // First stage wraps this cycle.
   logic second_tick; // Second stage wraps: receiver sample tick.
   logic bit_tick; // Sixteenth sample tick: transmit bit tick.
   logic chain_clear; // Momentary clear of the counter chains.
   logic [31:0] ctrl_word; // Read view of bit_rate_control.
   logic [sbrg_pkg::EVT_COUNT-1:0] status_word; // Sticky event bits.
   logic [sbrg_pkg::EVT_COUNT-1:0] clear_bits; // Write-one-to-clear bits.
   logic rx_data_read; // Receive data register read completes.

   // Address phase is taken while the bus is ready.
   assign addr_take = hsel && hready && (htrans == sbrg_pkg::HTRANS_NONSEQ);

   // Divider chain taps; both stage compares use >= so a lowered factor ends cleanly.
   assign first_tick = state_q.p1_cnt >= sbrg_first_term(state_q.first_sel);
   assign second_tick = first_tick &&
      (state_q.p2_cnt >= sbrg_second_term(state_q.second_sel));
   assign bit_tick = second_tick && (state_q.tx_cnt ==
      4'(sbrg_pkg::SAMPLES_PER_BIT - 5'h1));

   // The clear bit acts only in test or bootstrap mode and is not stored.
   assign chain_clear = state_q.wr_pend && test_or_boot_mode &&
      (state_q.addr == sbrg_pkg::ADDR_BIT_RATE_CONTROL) &&
      hwdata[sbrg_pkg::CTL_CHAIN_CLEAR];

   // Clear and test bits always read back as zero.
   always_comb begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[sbrg_pkg::CTL_SECOND_LSB +: 3] = state_q.second_sel;
      ctrl_word[sbrg_pkg::CTL_FIRST_LSB +: 2] = state_q.first_sel;
      ctrl_word[sbrg_pkg::CTL_SPI_SOURCE] = state_q.spi_src;
      ctrl_word[sbrg_pkg::CTL_CHAIN_CLEAR] = 1'b0;
      ctrl_word[sbrg_pkg::CTL_CLOCK_TEST] = 1'b0;
   end

   // Status view and write-one-to-clear strobes of the event register.
   assign status_word = {state_q.fe, state_q.ovr, state_q.rf};
   assign clear_bits = (state_q.wr_pend &&
      state_q.addr == sbrg_pkg::ADDR_EVENT_STATUS) ?
      hwdata[sbrg_pkg::EVT_COUNT-1:0] : '0;
   assign rx_data_read = state_q.rd_pend &&
      (state_q.addr == sbrg_pkg::ADDR_RX_DATA);

   // Next-state logic for the whole block.
   always_comb begin
      state_d = state_q;
      if (clock_enable) begin
         // Bus pipeline: remember the address phase for the data phase.
         state_d.wr_pend = addr_take && hwrite;
         state_d.rd_pend = addr_take && !hwrite;
         if (addr_take) begin
            state_d.addr = haddr[7:0];
         end
         // Register writes land in the data phase.
         if (state_q.wr_pend) begin
            unique case (state_q.addr)
               sbrg_pkg::ADDR_BIT_RATE_CONTROL: begin
                  state_d.second_sel = hwdata[sbrg_pkg::CTL_SECOND_LSB +: 3];
                  state_d.first_sel = hwdata[sbrg_pkg::CTL_FIRST_LSB +: 2];
                  state_d.spi_src = hwdata[sbrg_pkg::CTL_SPI_SOURCE];
                  state_d.clk_test = test_or_boot_mode &&
                     hwdata[sbrg_pkg::CTL_CLOCK_TEST];
               end
               sbrg_pkg::ADDR_EVENT_MASK: begin
                  state_d.mask = hwdata[sbrg_pkg::EVT_COUNT-1:0];
               end
               default: begin
                  // Other addresses hold no writable state.
               end
            endcase
         end
         // Outside test or bootstrap mode the test bit stays low.
         if (!test_or_boot_mode) begin
            state_d.clk_test = 1'b0;
         end
         // Shared divider chain for receiver and transmitter.
         if (chain_clear) begin
            state_d.p1_cnt = 4'h0;
            state_d.p2_cnt = '0;
            state_d.tx_cnt = 4'h0;
            state_d.rx_lvl = 1'b0;
            state_d.tx_lvl = 1'b0;
         end else begin
            state_d.p1_cnt = first_tick ? 4'h0 : state_q.p1_cnt + 4'h1;
            if (first_tick) begin
               // Second stage advances only on the first stage's output.
               state_d.p2_cnt = second_tick ? '0 :
                  state_q.p2_cnt + 1'b1;
            end
            if (second_tick) begin
               state_d.tx_cnt = state_q.tx_cnt + 4'h1;
               state_d.rx_lvl = !state_q.rx_lvl;
            end
            if (bit_tick) begin
               state_d.tx_lvl = !state_q.tx_lvl;
            end
         end
         // Pin shows the clock XOR in test mode, else transmit data.
         state_d.ser_out = state_q.clk_test ?
            (state_q.rx_lvl ^ state_q.tx_lvl) : tx_line_bit;
         // Software clears first; a same-cycle hardware set wins below.
         if (clear_bits[sbrg_pkg::EVT_RECEIVE_FULL] || rx_data_read) begin
            state_d.rf = 1'b0;
         end
         if (clear_bits[sbrg_pkg::EVT_OVERRUN]) begin
            state_d.ovr = 1'b0;
         end
         if (clear_bits[sbrg_pkg::EVT_FRAMING]) begin
            state_d.fe = 1'b0;
         end
         // Receive hand-over: framing error or overrun blocks the move.
         if (rx_shift_done) begin
            if (state_q.fe || state_q.ovr) begin
               // Character dropped while a flag is held.
               state_d.rx_data = state_q.rx_data;
            end else if (state_q.rf) begin
               state_d.ovr = 1'b1;
            end else begin
               state_d.rx_data = rx_shift_data;
               state_d.rf = 1'b1;
               if (rx_stop_bad) begin
                  state_d.fe = 1'b1;
               end
            end
         end
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q <= '0;
         state_q.first_sel <= sbrg_pkg::RST_BIT_RATE_CONTROL[5:4];
         state_q.second_sel <= sbrg_pkg::RST_BIT_RATE_CONTROL[2:0];
         state_q.spi_src <= sbrg_pkg::RST_BIT_RATE_CONTROL[6];
         state_q.mask <= sbrg_pkg::RST_EVENT_MASK;
      end else begin
         state_q <= state_d;
      end
   end

   // Zero-wait slave; unmapped reads return zero, writes are dropped.
   always_comb begin
      hrdata = 32'h0000_0000;
      if (state_q.rd_pend) begin
         unique case (state_q.addr)
            sbrg_pkg::ADDR_BIT_RATE_CONTROL: hrdata = ctrl_word;
            sbrg_pkg::ADDR_RX_DATA: hrdata = 32'(state_q.rx_data);
            sbrg_pkg::ADDR_EVENT_STATUS: hrdata = 32'(status_word);
            sbrg_pkg::ADDR_EVENT_MASK: hrdata = 32'(state_q.mask);
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Every transfer finishes at once with an OKAY response.
   assign hreadyout = 1'b1;
   assign hresp = sbrg_pkg::HRESP_OKAY;

   // Clock-enable outputs of the divider chain.
   assign rx_sample_tick = clock_enable && second_tick;
   assign tx_bit_tick = clock_enable && bit_tick;
   assign spi_clock_tick = state_q.spi_src ?
      rx_sample_tick : clock_enable;
   assign serial_output_pin = state_q.ser_out;
   assign receive_full_flag = state_q.rf;
   assign framing_error_flag = state_q.fe;

   // One level interrupt; it also wakes the system from wait.
   assign irq = |(status_word & state_q.mask);
   assign wake_request = irq;

   // Checks run on the bus clock and rest while reset is low.
   default clocking sbrg_cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_fe_blocks_data: assert property (
      clock_enable && rx_shift_done && state_q.fe |=>
      $stable(state_q.rx_data))
      else $error("Receive data changed while framing flag set.");
   a_fe_with_full: assert property (
      $rose(state_q.fe) |-> $rose(state_q.rf))
      else $error("Framing flag rose without receive full.");
   a_fe_not_overrun: assert property (
      clock_enable && rx_shift_done && state_q.rf && !state_q.fe &&
      !state_q.ovr |=> state_q.ovr && !$rose(state_q.fe))
      else $error("Overrun handled wrongly.");
   a_rx_tick_count: assert property (
      rx_sample_tick |-> state_q.p1_cnt ==
      sbrg_first_term(state_q.first_sel) || chain_clear ||
      $changed(state_q.first_sel))
      else $error("Sample tick at wrong first-stage count.");
   a_tx_sixteenth: assert property (
      tx_bit_tick |-> rx_sample_tick && state_q.tx_cnt == 4'hf)
      else $error("Bit tick not on sixteenth sample tick.");
   a_clear_chain: assert property (
      clock_enable && chain_clear |=>
      state_q.p1_cnt == 4'h0 && state_q.tx_cnt == 4'h0)
      else $error("Chain clear did not reset the counters.");
   // The first stage counts up by one until it wraps.
   a_first_steps: assert property (
      clock_enable && !chain_clear && !first_tick |=>
      state_q.p1_cnt == $past(state_q.p1_cnt) + 4'h1)
      else $error("First-stage counter skipped a count.");
   // The second stage moves only when the first stage wraps.
   a_second_holds: assert property (
      clock_enable && !chain_clear && !first_tick |=>
      $stable(state_q.p2_cnt))
      else $error("Second-stage counter moved without a first tick.");
   // Overrun or a full register leaves the held character untouched.
   a_held_data: assert property (
      clock_enable && rx_shift_done && (state_q.rf || state_q.ovr) |=>
      $stable(state_q.rx_data))
      else $error("Receive data overwritten while blocked.");
   a_ctrl_reads_zero: assert property (
      state_q.rd_pend && state_q.addr == sbrg_pkg::ADDR_BIT_RATE_CONTROL
      |-> !hrdata[sbrg_pkg::CTL_CHAIN_CLEAR] &&
      !hrdata[sbrg_pkg::CTL_CLOCK_TEST])
      else $error("Clear or test bit read back as one.");
   a_test_needs_mode: assert property (
      clock_enable && !test_or_boot_mode |=> !state_q.clk_test)
      else $error("Clock test bit set outside test mode.");
   a_test_xor_out: assert property (
      clock_enable && state_q.clk_test |=>
      serial_output_pin == ($past(state_q.rx_lvl) ^ $past(state_q.tx_lvl)))
      else $error("Test output is not the clock XOR.");
   a_spi_source: assert property (
      spi_clock_tick == (state_q.spi_src ? rx_sample_tick : clock_enable))
      else $error("SPI clock source routed wrongly.");
   a_wake_irq: assert property (
      clock_enable && rx_shift_done && !state_q.rf && !state_q.fe &&
      !state_q.ovr && state_q.mask[sbrg_pkg::EVT_RECEIVE_FULL] |=>
      wake_request)
      else $error("Unmasked receive event did not wake.");
endmodule
`default_nettype wire

// ==== sbrg_partner.sv ====
// Purpose: Remote serial side that hands received characters over.
// Assumes: One clock; the bench calls send to deliver one character.
// Notes:   Released data lines carry the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module sbrg_partner (
   input wire logic clock,
   output logic rx_shift_done,
   output logic [sbrg_pkg::RX_DATA_W-1:0] rx_shift_data,
   output logic rx_stop_bad,
   output logic tx_line_bit
);
   // Lines start idle so no character is handed over by accident.
   initial begin
      rx_shift_done = 1'b0;
      rx_shift_data = 9'h000;
      rx_stop_bad = 1'b0;
      tx_line_bit = 1'b0;
   end
   // The transmit bit toggles every cycle, so a stuck pin shows.
   always @(posedge clock) begin
      tx_line_bit <= ~tx_line_bit;
   end
   // Pulses one character for a single cycle, then releases the lines.
   task automatic send(input logic [8:0] d, input logic bad);
      @(posedge clock);
      rx_shift_done <= 1'b1;
      rx_shift_data <= d;
      rx_stop_bad <= bad;
      @(posedge clock);
      rx_shift_done <= 1'b0;
      rx_shift_data <= ~d;
      rx_stop_bad <= ~bad;
   endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Purpose: Self-checking bench for the serial bit-rate generator.
// Assumes: Zero-wait AHB-Lite slave; hready is looped from hreadyout.
// Notes:   Divider periods are measured from one tick to the next.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [7:0] CTRL = sbrg_pkg::ADDR_BIT_RATE_CONTROL;
   localparam logic [7:0] DATA = sbrg_pkg::ADDR_RX_DATA;
   localparam logic [7:0] STAT = sbrg_pkg::ADDR_EVENT_STATUS;
   localparam logic [7:0] MASK = sbrg_pkg::ADDR_EVENT_MASK;
   logic clock, rst_n, hsel, hwrite, mode, hreadyout, ce;
   logic [1:0] htrans, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd_s;
   logic rx_tick, tx_tick, spi_tick, pin, rf, fe, irq, wake;
   logic done, bad, txb, rdy_s, rx_s, tx_s, spi_s, pin_s, txb_s, txb_ss;
   logic [8:0] rdat;
   int err_count, tests_run, n, m;
   int ff[4] = '{1, 3, 4, 13};
   // The remote device feeds characters and the transmit bit.
   sbrg_partner u_sbrg_partner (.clock(clock), .rx_shift_done(done),
      .rx_shift_data(rdat), .rx_stop_bad(bad), .tx_line_bit(txb));
   // Device under test; hready follows the only slave.
   sbrg_top u_sbrg_top (.clock(clock), .rst_n(rst_n),
      .clock_enable(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .test_or_boot_mode(mode), .rx_shift_done(done),
      .rx_shift_data(rdat), .rx_stop_bad(bad), .tx_line_bit(txb),
      .rx_sample_tick(rx_tick), .tx_bit_tick(tx_tick),
      .spi_clock_tick(spi_tick), .serial_output_pin(pin),
      .receive_full_flag(rf), .framing_error_flag(fe), .irq(irq),
      .wake_request(wake));
   // Free-running bus clock of 40 ns.
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Captures outputs as they stood just before each edge.
   always @(posedge clock) begin
      rd_s <= hrdata;
      rdy_s <= hreadyout;
      rx_s <= rx_tick;
      tx_s <= tx_tick;
      spi_s <= spi_tick;
      pin_s <= pin;
      txb_s <= txb;
      txb_ss <= txb_s;
   end
   // Compares one value and counts the outcome.
   task automatic check(input string w, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", w, e, s);
      end
   endtask
   // Moves just past the next rising edge.
   task automatic step();
      @(posedge clock);
      #1;
   endtask
   // One single transfer; read data is left in rd_s.
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= sbrg_pkg::HTRANS_NONSEQ;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      do step(); while (rdy_s !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do step(); while (rdy_s !== 1'b1);
   endtask
   // Reads a register and compares it.
   task automatic rchk(input string w, input logic [7:0] a,
      input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(w, rd_s, e);
   endtask
   // Counts cycles between two rx ticks, or two tx ticks when t is set.
   task automatic meas(input bit t, output int k);
      do step(); while ((t ? tx_s : rx_s) !== 1'b1);
      k = 0;
      do begin
         step();
         k++;
      end while ((t ? tx_s : rx_s) !== 1'b1 && k < 40000);
   endtask
   // Counts cycles where the pin differs from the delayed transmit bit.
   task automatic pin_diff(output int k);
      k = 0;
      repeat (32) begin
         step();
         k += int'(pin_s !== txb_ss);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // A hang counts as a mismatch and ends the run.
   initial begin
      repeat (60000) @(posedge clock);
      err_count++;
      close_out();
   end
   // Main sequence of tests.
   initial begin
      {rst_n, hsel, hwrite, mode, htrans, haddr, hwdata} = '0;
      ce = 1'b1;
      err_count = 0;
      tests_run = 0;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      rchk("ctrl", CTRL, 32'h0);
      rchk("mask", MASK, 32'h0);
      rchk("status", STAT, 32'h0);
      check("hresp", 32'(hresp), 32'h0);
      $display("reset values done");
      // Every first and second stage code, period from tick to tick.
      for (int f = 0; f < 4; f++) begin
         for (int s = 0; s < 8; s++) begin
            bus(1'b1, CTRL, 32'((f << 4) | s));
            rchk("ctrl", CTRL, 32'((f << 4) | s));
            meas(1'b0, n);
            meas(1'b0, n);
            check("rx period", 32'(n), 32'(ff[f] << s));
         end
      end
      bus(1'b1, CTRL, 32'h11);
      meas(1'b1, m);
      meas(1'b1, m);
      check("tx period", 32'(m), 32'd96);
      $display("divider done");
      // SPI source follows rx ticks, else the bus clock enable.
      bus(1'b1, CTRL, 32'h51);
      repeat (12) begin
         step();
         check("spi rx", 32'(spi_s), 32'(rx_s));
      end
      bus(1'b1, CTRL, 32'h11);
      repeat (8) begin
         step();
         check("spi bus", 32'(spi_s), 32'h1);
      end
      // With the clock enable low no tick of any kind may appear.
      ce <= 1'b0;
      repeat (8) begin
         step();
         check("freeze", 32'({rx_s, tx_s, spi_s}), 32'h0);
      end
      ce <= 1'b1;
      $display("spi source done");
      // Test bits are ignored outside test mode and always read zero.
      bus(1'b1, CTRL, 32'h88);
      rchk("ctrl", CTRL, 32'h0);
      pin_diff(n);
      check("pin follows", 32'(n), 32'h0);
      @(posedge clock);
      mode <= 1'b1;
      bus(1'b1, CTRL, 32'h08);
      rchk("ctrl", CTRL, 32'h0);
      pin_diff(n);
      check("pin xor", 32'(n != 0), 32'h1);
      bus(1'b1, CTRL, 32'h80);
      rchk("ctrl", CTRL, 32'h0);
      @(posedge clock);
      mode <= 1'b0;
      $display("test bits done");
      // Interrupt masking, then framing and overrun gating.
      u_sbrg_partner.send(9'h1a5, 1'b0);
      step();
      check("irq masked", 32'({irq, wake}), 32'h0);
      bus(1'b1, MASK, 32'h7);
      rchk("mask", MASK, 32'h7);
      check("irq", 32'({irq, wake}), 32'h3);
      rchk("status", STAT, 32'h1);
      bus(1'b1, STAT, 32'h7);
      check("irq clear", 32'({irq, wake}), 32'h0);
      rchk("data", DATA, 32'h1a5);
      u_sbrg_partner.send(9'h05a, 1'b1);
      #1;
      check("rf fe", 32'({rf, fe}), 32'h3);
      u_sbrg_partner.send(9'h0ff, 1'b0);
      #1;
      rchk("status", STAT, 32'h5);
      rchk("data", DATA, 32'h05a);
      bus(1'b1, STAT, 32'h7);
      u_sbrg_partner.send(9'h011, 1'b0);
      u_sbrg_partner.send(9'h022, 1'b1);
      #1;
      check("fe overrun", 32'(fe), 32'h0);
      rchk("status", STAT, 32'h3);
      rchk("data", DATA, 32'h011);
      bus(1'b1, 8'h10, 32'hff);
      rchk("unmapped", 8'h10, 32'h0);
      $display("receive gating done");
      close_out();
   end
endmodule
`default_nettype wire
